//--- inc/rtcmfo_consts.svh
`ifndef RTCMFO_CONSTS_SVH
`define RTCMFO_CONSTS_SVH

// Register map.
`define RTCMFO_CTRL_OFFSET 8'h07
`define RTCMFO_CTRL_RESET 8'h80
`define RTCMFO_READ_ZERO 8'h00

// Field positions inside the output control register.
`define RTCMFO_BIT_LEVEL 7
`define RTCMFO_BIT_SQUARE_EN 6
`define RTCMFO_BIT_ALARM1_EN 5
`define RTCMFO_BIT_ALARM0_EN 4
`define RTCMFO_BIT_EXT_TIMEBASE 3
`define RTCMFO_BIT_COARSE_TRIM 2
`define RTCMFO_BIT_RATE_HI 1
`define RTCMFO_BIT_RATE_LO 0

// Rate select codes.
`define RTCMFO_RATE_DIV1 2'b00
`define RTCMFO_RATE_DIV4 2'b01
`define RTCMFO_RATE_DIV8 2'b10
`define RTCMFO_RATE_DIV32768 2'b11

// Half periods of the divided square wave, in oscillator rising edges.
`define RTCMFO_HALF_DIV4 15'h0002
`define RTCMFO_HALF_DIV8 15'h0004
`define RTCMFO_HALF_DIV32768 15'h4000
`define RTCMFO_HALF_COARSE 15'h0100

`define RTCMFO_CNT_ZERO 15'h0000
`define RTCMFO_CNT_ONE 15'h0001
`define RTCMFO_CNT_TWO 15'h0002

`endif

//--- inc/rtcmfo_pkg.sv
package rtcmfo_pkg;
  typedef enum logic [1:0] {
    RTCMFO_MODE_GENERAL = 2'b00,
    RTCMFO_MODE_ALARM = 2'b01,
    RTCMFO_MODE_SQUARE = 2'b10
  } rtcmfo_mode_t;

  typedef logic [14:0] rtcmfo_count_t;
endpackage

//--- design/rtcmfo_postscaler.sv
`timescale 1ns/1ps
`include "rtcmfo_consts.svh"

module rtcmfo_postscaler (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic restart_i,
  input wire logic trim_add_i,
  input wire logic trim_sub_i,
  input wire rtcmfo_pkg::rtcmfo_count_t half_i,
  output logic wave_o
);
  import rtcmfo_pkg::*;

  rtcmfo_count_t count;
  rtcmfo_count_t next_count;
  logic next_wave;
  rtcmfo_count_t step;
  rtcmfo_count_t sum;

  // A trim pulse adds or removes one oscillator edge from the count, which
  // stretches or shrinks one half period.
  always_comb begin
    step = `RTCMFO_CNT_ZERO;
    if (tick_i && !trim_sub_i) begin
      step = `RTCMFO_CNT_ONE;
    end
    if (trim_add_i) begin
      step = step + `RTCMFO_CNT_ONE;
    end
    sum = count + step;
    next_count = count;
    next_wave = wave_o;
    if (restart_i) begin
      next_count = `RTCMFO_CNT_ZERO;
      next_wave = 1'b0;
    end else if (sum >= half_i) begin
      next_count = sum - half_i;
      next_wave = !wave_o;
    end else begin
      next_count = sum;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count <= `RTCMFO_CNT_ZERO;
      wave_o <= 1'b0;
    end else begin
      count <= next_count;
      wave_o <= next_wave;
    end
  end
endmodule

//--- design/rtcmfo_top.sv
// Operation
// - Control bit 5 enables second alarm.
// - Control bit 4 enables first alarm.
// - Bit 3 selects external timebase source.
// - Bit 2 coarse trim, square gives 64 Hz.
// - Rate select divides 1, 4, 8, 32768.
// - Trim affects all rates except 1:1.
// - No square wave on backup supply.
// - Alarm output when alarm on, square off.
// - Alarm output still works on backup.
// - Single alarm: flag, or inverse by polarity.
// - Both alarms, polarity one: OR flags.
// - Both alarms, polarity zero: NAND flags.
// - All off: pin follows level bit, released on backup.
// - Bit 6 square enable, highest priority.
`timescale 1ns/1ps
`include "rtcmfo_consts.svh"

module rtcmfo_top (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [7:0] REG_RDATA_O,
  output logic REG_ACK_O,
  input wire logic CRYSTAL_CLK_I,
  input wire logic OSC_INPUT_PIN_I,
  input wire logic BACKUP_I,
  input wire logic FIRST_ALARM_FLAG_I,
  input wire logic SECOND_ALARM_FLAG_I,
  input wire logic ALARM_OUTPUT_POLARITY_I,
  input wire logic TRIM_ADD_I,
  input wire logic TRIM_SUB_I,
  output logic MULTI_FUNCTION_PIN_O,
  output logic MULTI_FUNCTION_PIN_OE_O,
  output logic CRYSTAL_RUN_O,
  output logic EXTERNAL_TIMEBASE_SELECT_O,
  output logic COARSE_TRIM_ENABLE_O,
  output logic FIRST_ALARM_ENABLE_O,
  output logic SECOND_ALARM_ENABLE_O,
  output logic [1:0] PIN_MODE_O
);
  import rtcmfo_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  // Half period lookup; coarse trim overrides the rate select field.
  function automatic rtcmfo_count_t rate_half(input logic [1:0] sel, input logic coarse);
    rtcmfo_count_t h;
    h = `RTCMFO_HALF_DIV32768;
    if (coarse) begin
      h = `RTCMFO_HALF_COARSE;
    end else begin
      case (sel)
        `RTCMFO_RATE_DIV4: h = `RTCMFO_HALF_DIV4;
        `RTCMFO_RATE_DIV8: h = `RTCMFO_HALF_DIV8;
        default: h = `RTCMFO_HALF_DIV32768;
      endcase
    end
    return h;
  endfunction

  // Alarm interrupt level from the enables, flags and polarity.
  function automatic logic alarm_level(input logic en0, input logic en1, input logic f0,
                                       input logic f1, input logic pol);
    logic lvl;
    lvl = 1'b1;
    if (en0 && en1) begin
      if (pol) begin
        lvl = f0 | f1;
      end else begin
        lvl = !(f0 & f1);
      end
    end else if (en0) begin
      lvl = pol ? f0 : !f0;
    end else if (en1) begin
      lvl = pol ? f1 : !f1;
    end
    return lvl;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Control register.

  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] next_rdata;
  logic next_ack;
  logic addr_hit;

  assign addr_hit = (REG_ADDR_I == `RTCMFO_CTRL_OFFSET);

  always_comb begin
    next_ctrl = ctrl;
    next_rdata = `RTCMFO_READ_ZERO;
    next_ack = REG_WR_I | REG_RD_I;
    if (REG_WR_I && addr_hit) begin
      next_ctrl = REG_WDATA_I;
    end
    // Other addresses belong to neighbouring blocks and read as zero here.
    if (REG_RD_I && addr_hit) begin
      next_rdata = ctrl;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      ctrl <= `RTCMFO_CTRL_RESET;
      REG_RDATA_O <= `RTCMFO_READ_ZERO;
      REG_ACK_O <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      REG_RDATA_O <= next_rdata;
      REG_ACK_O <= next_ack;
    end
  end

  logic level_bit;
  logic square_en;
  logic alarm1_en;
  logic alarm0_en;
  logic ext_sel;
  logic coarse_en;
  logic [1:0] rate_sel;

  assign level_bit = ctrl[`RTCMFO_BIT_LEVEL];
  assign square_en = ctrl[`RTCMFO_BIT_SQUARE_EN];
  assign alarm1_en = ctrl[`RTCMFO_BIT_ALARM1_EN];
  assign alarm0_en = ctrl[`RTCMFO_BIT_ALARM0_EN];
  assign ext_sel = ctrl[`RTCMFO_BIT_EXT_TIMEBASE];
  assign coarse_en = ctrl[`RTCMFO_BIT_COARSE_TRIM];
  assign rate_sel = ctrl[`RTCMFO_BIT_RATE_HI:`RTCMFO_BIT_RATE_LO];

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Three stages; a new level is accepted only when the
  // second and third stages agree, which filters a single metastable sample.

  logic [2:0] xtal_sync;
  logic [2:0] ext_sync;
  logic [2:0] bkp_sync;
  logic [2:0] next_xtal_sync;
  logic [2:0] next_ext_sync;
  logic [2:0] next_bkp_sync;
  logic xtal_lvl;
  logic ext_lvl;
  logic backup;
  logic next_xtal_lvl;
  logic next_ext_lvl;
  logic next_backup;

  always_comb begin
    next_xtal_sync = {xtal_sync[1:0], CRYSTAL_CLK_I};
    next_ext_sync = {ext_sync[1:0], OSC_INPUT_PIN_I};
    next_bkp_sync = {bkp_sync[1:0], BACKUP_I};
    next_xtal_lvl = (xtal_sync[1] == xtal_sync[2]) ? xtal_sync[2] : xtal_lvl;
    next_ext_lvl = (ext_sync[1] == ext_sync[2]) ? ext_sync[2] : ext_lvl;
    next_backup = (bkp_sync[1] == bkp_sync[2]) ? bkp_sync[2] : backup;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      xtal_sync <= 3'h0;
      ext_sync <= 3'h0;
      bkp_sync <= 3'h0;
      xtal_lvl <= 1'b0;
      ext_lvl <= 1'b0;
      backup <= 1'b0;
    end else begin
      xtal_sync <= next_xtal_sync;
      ext_sync <= next_ext_sync;
      bkp_sync <= next_bkp_sync;
      xtal_lvl <= next_xtal_lvl;
      ext_lvl <= next_ext_lvl;
      backup <= next_backup;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Timebase selection and edge detection.

  logic osc_lvl;
  logic osc_prev;
  logic next_osc_prev;
  logic osc_tick;

  assign osc_lvl = ext_sel ? ext_lvl : xtal_lvl;
  assign osc_tick = osc_lvl && !osc_prev;

  always_comb begin
    next_osc_prev = osc_lvl;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= next_osc_prev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Postscaler restart tracking.

  logic [1:0] rate_prev;
  logic square_prev;
  logic coarse_prev;
  logic [1:0] next_rate_prev;
  logic next_square_prev;
  logic next_coarse_prev;
  logic restart;

  // Restarting on a rate or coarse trim change and on square enable costs one shortened cycle at most,
  // but avoids a runt pulse from a count left over from the old rate.
  assign restart = (rate_sel != rate_prev) || (square_en && !square_prev) ||
                   (coarse_en != coarse_prev);

  always_comb begin
    next_rate_prev = rate_sel;
    next_square_prev = square_en;
    next_coarse_prev = coarse_en;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      rate_prev <= `RTCMFO_RATE_DIV1;
      square_prev <= 1'b0;
      coarse_prev <= 1'b0;
    end else begin
      rate_prev <= next_rate_prev;
      square_prev <= next_square_prev;
      coarse_prev <= next_coarse_prev;
    end
  end

  logic divided_wave;
  logic trim_active;
  logic square_wave;

  // The undivided rate bypasses the trim pulses entirely.
  assign trim_active = coarse_en || (rate_sel != `RTCMFO_RATE_DIV1);

  rtcmfo_postscaler u_postscaler (
    .ref_clk_i(REF_CLK_I),
    .rst_i(RST_I),
    .tick_i(osc_tick),
    .restart_i(restart),
    .trim_add_i(TRIM_ADD_I && trim_active),
    .trim_sub_i(TRIM_SUB_I && trim_active),
    .half_i(rate_half(rate_sel, coarse_en)),
    .wave_o(divided_wave)
  );

  always_comb begin
    if (!coarse_en && rate_sel == `RTCMFO_RATE_DIV1) begin
      square_wave = osc_lvl;
    end else begin
      square_wave = divided_wave;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output multiplexer. The pin is open drain: it is only ever pulled low,
  // and a high level is left to the external pull-up.

  rtcmfo_mode_t mode;
  logic pin_level;
  logic pin_drive;
  logic next_pin_oe;
  logic next_crystal_run;

  always_comb begin
    if (square_en) begin
      mode = RTCMFO_MODE_SQUARE;
    end else if (alarm0_en || alarm1_en) begin
      mode = RTCMFO_MODE_ALARM;
    end else begin
      mode = RTCMFO_MODE_GENERAL;
    end
  end

  always_comb begin
    pin_level = 1'b1;
    pin_drive = 1'b1;
    case (mode)
      RTCMFO_MODE_SQUARE: begin
        pin_level = square_wave;
        pin_drive = !backup;
      end
      RTCMFO_MODE_ALARM: begin
        // Flags feed straight in, so a flag change needs no register write.
        pin_level = alarm_level(alarm0_en, alarm1_en, FIRST_ALARM_FLAG_I,
                                SECOND_ALARM_FLAG_I, ALARM_OUTPUT_POLARITY_I);
        pin_drive = 1'b1;
      end
      RTCMFO_MODE_GENERAL: begin
        pin_level = level_bit;
        pin_drive = !backup;
      end
      default: begin
        pin_level = 1'b1;
        pin_drive = 1'b0;
      end
    endcase
    next_pin_oe = pin_drive && !pin_level;
    next_crystal_run = !ext_sel;
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      MULTI_FUNCTION_PIN_O <= 1'b0;
      MULTI_FUNCTION_PIN_OE_O <= 1'b0;
      CRYSTAL_RUN_O <= 1'b1;
      EXTERNAL_TIMEBASE_SELECT_O <= 1'b0;
      COARSE_TRIM_ENABLE_O <= 1'b0;
      FIRST_ALARM_ENABLE_O <= 1'b0;
      SECOND_ALARM_ENABLE_O <= 1'b0;
      PIN_MODE_O <= RTCMFO_MODE_GENERAL;
    end else begin
      MULTI_FUNCTION_PIN_O <= 1'b0;
      MULTI_FUNCTION_PIN_OE_O <= next_pin_oe;
      CRYSTAL_RUN_O <= next_crystal_run;
      EXTERNAL_TIMEBASE_SELECT_O <= ext_sel;
      COARSE_TRIM_ENABLE_O <= coarse_en;
      FIRST_ALARM_ENABLE_O <= alarm0_en;
      SECOND_ALARM_ENABLE_O <= alarm1_en;
      PIN_MODE_O <= mode;
    end
  end
endmodule

//--- testbench/rtcmfo_pull_model.sv
`timescale 1ns/1ps
module rtcmfo_pull_model (
  input wire logic pin_i,
  input wire logic oe_i,
  output wire logic level_o
);
  // The board pull-up is what makes a released pin read high.
  assign level_o = oe_i ? pin_i : 1'b1;
endmodule

//--- testbench/rtcmfo_monitor.sv
`timescale 1ns/1ps
module rtcmfo_monitor (
  input wire logic REF_CLK_I,
  input wire logic RST_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic BACKUP_I,
  input wire logic FIRST_ALARM_FLAG_I,
  input wire logic SECOND_ALARM_FLAG_I,
  input wire logic ALARM_OUTPUT_POLARITY_I,
  input wire logic MULTI_FUNCTION_PIN_OE_O,
  input wire logic CRYSTAL_RUN_O,
  input wire logic EXTERNAL_TIMEBASE_SELECT_O,
  input wire logic COARSE_TRIM_ENABLE_O,
  input wire logic FIRST_ALARM_ENABLE_O,
  input wire logic SECOND_ALARM_ENABLE_O,
  input wire logic [1:0] PIN_MODE_O
);
  logic f0q, f1q, polq;
  logic [7:0] wd1, wd2;
  logic [2:0] bk_cnt;
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RST_I);
  always_ff @(posedge REF_CLK_I) begin
    f0q <= FIRST_ALARM_FLAG_I;
    f1q <= SECOND_ALARM_FLAG_I;
    polq <= ALARM_OUTPUT_POLARITY_I;
    wd1 <= REG_WDATA_I;
    wd2 <= wd1;
    bk_cnt <= !BACKUP_I ? 3'h0 : ((bk_cnt == 3'h7) ? bk_cnt : bk_cnt + 3'h1);
  end
  //////////////////////////////////////////////////////////////////////////////
  sequence s_wr;
    REG_WR_I && REG_ADDR_I == 8'h07;
  endsequence
  property p_enables;
    s_wr |-> ##2 FIRST_ALARM_ENABLE_O == wd2[4] && SECOND_ALARM_ENABLE_O == wd2[5];
  endproperty
  a_enables: assert property (p_enables) else $error("alarm enables wrong");
  property p_timebase;
    s_wr |-> ##2 EXTERNAL_TIMEBASE_SELECT_O == wd2[3] && CRYSTAL_RUN_O == !wd2[3];
  endproperty
  a_timebase: assert property (p_timebase) else $error("timebase select wrong");
  property p_coarse;
    s_wr |-> ##2 COARSE_TRIM_ENABLE_O == wd2[2];
  endproperty
  a_coarse: assert property (p_coarse) else $error("coarse trim wrong");
  property p_mode;
    s_wr |-> ##2 PIN_MODE_O == (wd2[6] ? 2'b10 : ((|wd2[5:4]) ? 2'b01 : 2'b00));
  endproperty
  a_mode: assert property (p_mode) else $error("pin mode wrong");
  // Backup is left out on purpose: alarm output must survive it.
  property p_single;
    PIN_MODE_O == 2'b01 && (FIRST_ALARM_ENABLE_O ^ SECOND_ALARM_ENABLE_O)
      |-> MULTI_FUNCTION_PIN_OE_O == ((FIRST_ALARM_ENABLE_O ? f0q : f1q) ^ polq);
  endproperty
  a_single: assert property (p_single) else $error("single alarm pin wrong");
  property p_both_or;
    PIN_MODE_O == 2'b01 && FIRST_ALARM_ENABLE_O && SECOND_ALARM_ENABLE_O && polq
      |-> MULTI_FUNCTION_PIN_OE_O == !(f0q || f1q);
  endproperty
  a_both_or: assert property (p_both_or) else $error("dual alarm or wrong");
  property p_both_nand;
    PIN_MODE_O == 2'b01 && FIRST_ALARM_ENABLE_O && SECOND_ALARM_ENABLE_O && !polq
      |-> MULTI_FUNCTION_PIN_OE_O == (f0q && f1q);
  endproperty
  a_both_nand: assert property (p_both_nand) else $error("dual alarm nand wrong");
  property p_backup;
    bk_cnt > 3'h5 && PIN_MODE_O != 2'b01 |-> !MULTI_FUNCTION_PIN_OE_O;
  endproperty
  a_backup: assert property (p_backup) else $error("pin driven on backup");
  c_square: cover property (s_wr ##2 PIN_MODE_O == 2'b10);
  c_alarm: cover property (PIN_MODE_O == 2'b01 && MULTI_FUNCTION_PIN_OE_O);
  c_backup: cover property (bk_cnt > 3'h5 && PIN_MODE_O == 2'b01);
endmodule
bind rtcmfo_top rtcmfo_monitor i_mon (.*);

//--- testbench/rtcmfo_top_test.sv
`timescale 1ns/1ps
module rtcmfo_top_test;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bk = 1'b0;
  logic f0 = 1'b0, f1 = 1'b0, pol = 1'b0, trim_on = 1'b0, t_add = 1'b0, t_sub = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [3:0] osc = 4'h0;
  logic ack, pin, oe, xrun, ext, coarse, fe, se;
  logic [1:0] mode;
  wire level;
  int mismatches = 0, check_count = 0;
  logic [7:0] sq_ctrl [6] = '{8'h40, 8'h41, 8'h42, 8'h47, 8'h49, 8'h41};
  int sq_exp [6] = '{1024, 256, 128, 2, 128, 0};
  always #25 clk = ~clk;
  // Crystal runs at an eighth of the system clock, the external source at a sixteenth.
  always @(posedge clk) begin
    osc <= osc + 4'h1;
    t_add <= trim_on & 1'($urandom);
    t_sub <= trim_on & 1'($urandom);
  end
  rtcmfo_top i_dut (.REF_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_ACK_O(ack), .CRYSTAL_CLK_I(osc[2]), .OSC_INPUT_PIN_I(osc[3]),
    .BACKUP_I(bk), .FIRST_ALARM_FLAG_I(f0), .SECOND_ALARM_FLAG_I(f1), .ALARM_OUTPUT_POLARITY_I(pol),
    .TRIM_ADD_I(t_add), .TRIM_SUB_I(t_sub), .MULTI_FUNCTION_PIN_O(pin), .MULTI_FUNCTION_PIN_OE_O(oe),
    .CRYSTAL_RUN_O(xrun), .EXTERNAL_TIMEBASE_SELECT_O(ext), .COARSE_TRIM_ENABLE_O(coarse),
    .FIRST_ALARM_ENABLE_O(fe), .SECOND_ALARM_ENABLE_O(se), .PIN_MODE_O(mode));
  rtcmfo_pull_model i_pull (.pin_i(pin), .oe_i(oe), .level_o(level));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  // Edge counts get one edge of slack for the restart phase.
  task automatic chk_near(input int got, input int exp);
    check_count++;
    if (got < exp - 1 || got > exp + 1) begin
      mismatches++;
      $display("wrong value at %0t ns: %0d edges, expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
    chk({7'h00, ack}, 8'h01);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic alarm_level(input logic [1:0] en, input logic p, input logic a, input logic b);
    logic f;
    f = (en == 2'b11) ? (p ? (a | b) : (a & b)) : (en[0] ? a : b);
    return f ~^ p;
  endfunction
  task automatic close_out;
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v, a, d;
    int n;
    logic prev;
    void'($urandom(49));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(8'h07, d);
    chk(d, 8'h80);
    chk({7'h00, level}, 8'h01);
    for (int i = 0; i < 16; i++) begin
      v = 8'($urandom);
      a = 8'($urandom);
      if (a == 8'h07) a = 8'h08;
      wr_reg(8'h07, v);
      wr_reg(a, ~v);
      rd_reg(8'h07, d);
      chk(d, v);
      rd_reg(a, d);
      chk(d, 8'h00);
      chk({3'h0, xrun, se, fe, ext, coarse}, {3'h0, ~v[3], v[5:2]});
    end
    for (int k = 8; k < 32; k++) begin
      wr_reg(8'h07, {1'($urandom), 1'b0, k[4:3], 4'h0});
      pol <= k[2];
      f0 <= k[1];
      f1 <= k[0];
      bk <= 1'($urandom);
      settle(7);
      chk({7'h00, level}, {7'h00, alarm_level(k[4:3], k[2], k[1], k[0])});
    end
    @(posedge clk);
    f0 <= 1'b0;
    f1 <= 1'b0;
    settle(3);
    chk({7'h00, level}, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr_reg(8'h07, {k[0], 7'h00});
      bk <= k[1];
      settle(7);
      chk({7'h00, level}, {7'h00, k[1] | k[0]});
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      trim_on <= (i == 0);
      bk <= (i == 5);
      wr_reg(8'h07, sq_ctrl[i]);
      settle(8);
      n = 0;
      prev = level;
      repeat (8192) begin
        @(posedge clk);
        #1;
        if (prev && !level) n++;
        prev = level;
      end
      chk_near(n, sq_exp[i]);
    end
    close_out();
  end
  // The full run needs about 50000 cycles; 80000 leaves margin.
  initial begin
    #4_000_000;
    mismatches++;
    close_out();
  end
endmodule
